// ==== verilog/ppm_monitor_defs.svh ====
// Constants for the port performance monitor: widths, counter indices and limits
`ifndef PPM_MONITOR_DEFS_SVH
`define PPM_MONITOR_DEFS_SVH

`define PPM_CNT_W 32
`define PPM_CNT_MAX 32'hffffffff
`define PPM_CNT_ZERO 32'h00000000
`define PPM_CNT_ONE 32'h00000001
`define PPM_NUM_CNT 7
`define PPM_SEL_W 3
`define PPM_DEPTH_W 8
`define PPM_WORDS_W 8
`define PPM_PRESC_W 16
`define PPM_PRESC_ZERO 16'h0000
`define PPM_PRESC_ONE 16'h0001

// Counter indices on the select port
`define PPM_IDX_STAT0 3'h0
`define PPM_IDX_STAT1 3'h1
`define PPM_IDX_TX_CONG 3'h2
`define PPM_IDX_TX_PERIOD 3'h3
`define PPM_IDX_RX_CONG 3'h4
`define PPM_IDX_RX_PERIOD 3'h5
`define PPM_IDX_REORDER 3'h6

// Priority codes
`define PPM_PRIO_0 2'h0
`define PPM_PRIO_1 2'h1
`define PPM_PRIO_2 2'h2
`define PPM_PRIO_3 2'h3

`endif

// ==== verilog/ppm_pkg.sv ====
// Types shared by the port performance monitor
package ppm_pkg;

	// What a statistics counter counts
	typedef enum logic [1:0] {
		PPM_MODE_WORDS,
		PPM_MODE_ALL,
		PPM_MODE_PRIO
	} ppm_mode_t;

	// Link direction seen by a statistics counter
	typedef enum logic {
		PPM_DIR_TX,
		PPM_DIR_RX
	} ppm_dir_t;

	// Egress arbitration policy of the switch fabric
	typedef enum logic [1:0] {
		PPM_ARB_OLDEST,
		PPM_ARB_STRICT1,
		PPM_ARB_STRICT2
	} ppm_arb_t;

	// Transmit scheduler state
	typedef enum logic {
		PPM_SCHED_OLDEST,
		PPM_SCHED_HIGHEST
	} ppm_sched_t;

	// One packet end seen on the link
	typedef struct packed {
		logic valid;
		logic retried;
		logic [1:0] prio;
		logic [7:0] words;
	} ppm_pkt_t;

	// Configuration of one statistics counter
	typedef struct packed {
		ppm_mode_t mode;
		ppm_dir_t dir;
		logic [1:0] prio;
	} ppm_stat_cfg_t;

endpackage

// ==== verilog/ppm_monitor.sv ====
// Port performance monitor: statistics, congestion, reorder counters and egress selection
//
// Contract
// - Counter may count one selected priority, tx/rx
// - Retried packets never increment statistics counters
// - Per-direction programmable queue depth watermark
// - Count separate rises above watermark per direction
// - Accumulate time above watermark, programmable resolution
// - Congestion count past limit raises irq/port-write
// - Stalled packet passed by another is reordered
// - Reorder counter increments once per event
// - Reorder counter reaching threshold raises interrupt
// - Performance registers are readable and writable
// - Read returns value then clears it
// - Counters saturate at maximum, never wrap
// - Three egress arbitration policies selectable
// - Oldest-first, after retry highest priority, resume
// - Each port holds its own full set
// - Counter may count words or all packets
`timescale 1ns/1ps
`include "ppm_monitor_defs.svh"

module ppm_monitor (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire ppm_pkg::ppm_pkt_t tx_pkt,
	input wire ppm_pkg::ppm_pkt_t rx_pkt,
	input wire logic [`PPM_DEPTH_W-1:0] tx_depth,
	input wire logic [`PPM_DEPTH_W-1:0] rx_depth,
	input wire logic pkt_stalled,
	input wire logic pkt_passed,
	input wire ppm_pkg::ppm_stat_cfg_t stat0_cfg,
	input wire ppm_pkg::ppm_stat_cfg_t stat1_cfg,
	input wire logic [`PPM_DEPTH_W-1:0] tx_watermark,
	input wire logic [`PPM_DEPTH_W-1:0] rx_watermark,
	input wire logic [`PPM_PRESC_W-1:0] period_prescale,
	input wire logic [`PPM_CNT_W-1:0] cong_limit,
	input wire logic cong_irq_en,
	input wire logic cong_pw_en,
	input wire logic [`PPM_CNT_W-1:0] reorder_thresh,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [`PPM_SEL_W-1:0] reg_sel,
	input wire logic [`PPM_CNT_W-1:0] reg_wdata,
	input wire ppm_pkg::ppm_arb_t arb_policy,
	input wire logic [3:0] arb_pending,
	input wire logic [1:0] arb_oldest_prio,
	input wire logic sched_retry,
	input wire logic sched_sent,
	output logic [`PPM_CNT_W-1:0] reg_rdata,
	output logic reg_rvalid,
	output logic cong_irq,
	output logic cong_port_write,
	output logic reorder_irq,
	output logic [1:0] arb_grant_prio,
	output logic sched_send_highest
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Amount one statistics counter adds for the packets of this cycle
	function automatic logic [`PPM_CNT_W-1:0] stat_inc(
		input ppm_pkg::ppm_stat_cfg_t cfg,
		input ppm_pkg::ppm_pkt_t tx,
		input ppm_pkg::ppm_pkt_t rx
	);
		ppm_pkg::ppm_pkt_t p;
		logic take;
		p = (cfg.dir == ppm_pkg::PPM_DIR_TX) ? tx : rx;
		take = p.valid && !p.retried;
		stat_inc = `PPM_CNT_ZERO;
		if (take) begin
			case (cfg.mode)
				ppm_pkg::PPM_MODE_WORDS: stat_inc = {24'h000000, p.words};
				ppm_pkg::PPM_MODE_ALL: stat_inc = `PPM_CNT_ONE;
				ppm_pkg::PPM_MODE_PRIO: begin
					if (p.prio == cfg.prio) begin
						stat_inc = `PPM_CNT_ONE;
					end
				end
				default: stat_inc = `PPM_CNT_ZERO;
			endcase
		end
	endfunction

	// Saturating add; the counter sticks at all ones
	function automatic logic [`PPM_CNT_W-1:0] sat_add(
		input logic [`PPM_CNT_W-1:0] a,
		input logic [`PPM_CNT_W-1:0] b
	);
		logic [`PPM_CNT_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[`PPM_CNT_W] ? `PPM_CNT_MAX : s[`PPM_CNT_W-1:0];
	endfunction

	// Highest priority with a pending request
	function automatic logic [1:0] top_prio(input logic [3:0] pend);
		top_prio = `PPM_PRIO_0;
		if (pend[3]) begin
			top_prio = `PPM_PRIO_3;
		end else if (pend[2]) begin
			top_prio = `PPM_PRIO_2;
		end else if (pend[1]) begin
			top_prio = `PPM_PRIO_1;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Congestion detection

	logic tx_above_q;
	logic rx_above_q;
	logic [`PPM_PRESC_W-1:0] presc_cnt;
	wire logic tx_above = tx_depth > tx_watermark;
	wire logic rx_above = rx_depth > rx_watermark;
	wire logic tx_rise = tx_above && !tx_above_q;
	wire logic rx_rise = rx_above && !rx_above_q;
	// A prescale of zero is taken as one so the period counter never freezes
	wire logic presc_tick = (presc_cnt >= period_prescale) ||
		(period_prescale == `PPM_PRESC_ZERO);
	wire logic reorder_evt = pkt_stalled && pkt_passed;

	// Previous comparison results and the shared resolution prescaler
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_above_q <= 1'b0;
			rx_above_q <= 1'b0;
			presc_cnt <= `PPM_PRESC_ONE;
		end else begin
			tx_above_q <= tx_above;
			rx_above_q <= rx_above;
			presc_cnt <= presc_tick ? `PPM_PRESC_ONE : presc_cnt + `PPM_PRESC_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter bank, one private set per port instance

	logic [`PPM_CNT_W-1:0] cnt [`PPM_NUM_CNT];
	logic [`PPM_CNT_W-1:0] inc [`PPM_NUM_CNT];
	logic [`PPM_CNT_W-1:0] next_cnt [`PPM_NUM_CNT];

	// Increment sources
	assign inc[`PPM_IDX_STAT0] = stat_inc(stat0_cfg, tx_pkt, rx_pkt);
	assign inc[`PPM_IDX_STAT1] = stat_inc(stat1_cfg, tx_pkt, rx_pkt);
	assign inc[`PPM_IDX_TX_CONG] = {31'h00000000, tx_rise};
	assign inc[`PPM_IDX_TX_PERIOD] = {31'h00000000, tx_above && presc_tick};
	assign inc[`PPM_IDX_RX_CONG] = {31'h00000000, rx_rise};
	assign inc[`PPM_IDX_RX_PERIOD] = {31'h00000000, rx_above && presc_tick};
	assign inc[`PPM_IDX_REORDER] = {31'h00000000, reorder_evt};

	// A write loads, a read clears; an event in the same cycle still lands on top
	genvar gi;
	generate
		for (gi = 0; gi < `PPM_NUM_CNT; gi++) begin : g_cnt
			wire logic hit = reg_sel == `PPM_SEL_W'(gi);
			wire logic [`PPM_CNT_W-1:0] base = (reg_wr && hit) ? reg_wdata :
				(reg_rd && hit) ? `PPM_CNT_ZERO : cnt[gi];
			assign next_cnt[gi] = sat_add(base, inc[gi]);

			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					cnt[gi] <= `PPM_CNT_ZERO;
				end else begin
					cnt[gi] <= next_cnt[gi];
				end
			end
		end
	endgenerate

	// Read data shows the value held before the clearing edge
	wire logic sel_ok = reg_sel < `PPM_NUM_CNT;
	wire logic [`PPM_CNT_W-1:0] rd_val = sel_ok ? cnt[reg_sel] : `PPM_CNT_ZERO;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= `PPM_CNT_ZERO;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_val;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Threshold alarms, one-cycle pulses on the crossing step

	wire logic limit_top = cong_limit == `PPM_CNT_MAX;
	wire logic [`PPM_CNT_W-1:0] limit_next = cong_limit + `PPM_CNT_ONE;
	// Saturated limit can never be passed, so no alarm in that case
	wire logic tx_pass = inc[`PPM_IDX_TX_CONG] != `PPM_CNT_ZERO &&
		next_cnt[`PPM_IDX_TX_CONG] == limit_next && !limit_top;
	wire logic rx_pass = inc[`PPM_IDX_RX_CONG] != `PPM_CNT_ZERO &&
		next_cnt[`PPM_IDX_RX_CONG] == limit_next && !limit_top;
	wire logic cong_pass = tx_pass || rx_pass;
	wire logic reorder_hit = reorder_evt &&
		next_cnt[`PPM_IDX_REORDER] == reorder_thresh;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cong_irq <= 1'b0;
			cong_port_write <= 1'b0;
			reorder_irq <= 1'b0;
		end else begin
			cong_irq <= cong_pass && cong_irq_en;
			cong_port_write <= cong_pass && cong_pw_en;
			reorder_irq <= reorder_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Egress arbitration and transmit scheduling

	ppm_pkg::ppm_sched_t sched_state;
	ppm_pkg::ppm_sched_t next_sched_state;
	logic [1:0] next_grant;
	wire logic [1:0] highest = top_prio(arb_pending);

	// Strict 1 only lets priority 3 jump the queue; strict 2 orders every level
	always_comb begin
		case (arb_policy)
			ppm_pkg::PPM_ARB_OLDEST: next_grant = arb_oldest_prio;
			ppm_pkg::PPM_ARB_STRICT1: next_grant = arb_pending[3] ? `PPM_PRIO_3 :
				arb_oldest_prio;
			ppm_pkg::PPM_ARB_STRICT2: next_grant = highest;
			default: next_grant = arb_oldest_prio;
		endcase
	end

	// After a retry the highest priority goes once, then oldest-first resumes
	always_comb begin
		case (sched_state)
			ppm_pkg::PPM_SCHED_OLDEST: next_sched_state = sched_retry ?
				ppm_pkg::PPM_SCHED_HIGHEST : ppm_pkg::PPM_SCHED_OLDEST;
			ppm_pkg::PPM_SCHED_HIGHEST: next_sched_state = sched_sent ?
				ppm_pkg::PPM_SCHED_OLDEST : ppm_pkg::PPM_SCHED_HIGHEST;
			default: next_sched_state = ppm_pkg::PPM_SCHED_OLDEST;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sched_state <= ppm_pkg::PPM_SCHED_OLDEST;
			sched_send_highest <= 1'b0;
			arb_grant_prio <= `PPM_PRIO_0;
		end else begin
			sched_state <= next_sched_state;
			sched_send_highest <= next_sched_state == ppm_pkg::PPM_SCHED_HIGHEST;
			arb_grant_prio <= next_grant;
		end
	end

endmodule

// ==== test/ppm_queue_model.sv ====
// Fabric queue model feeding occupancy to the monitor
`timescale 1ns/1ps
module ppm_queue_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic push,
	input wire logic pop,
	output logic [7:0] tx_depth,
	output logic [7:0] rx_depth
);
	////////////////
	// One packet in or out per cycle; a full queue refuses more
	function automatic logic [7:0] step(input logic [7:0] d, input logic [7:0] cap);
		return (push && d < cap) ? d + 8'h01 : (pop && d != 8'h00) ? d - 8'h01 : d;
	endfunction
	// Caps are the high-priority acceptance limits
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_depth <= 8'h00;
			rx_depth <= 8'h00;
		end else begin
			tx_depth <= step(tx_depth, 8'h06);
			rx_depth <= step(rx_depth, 8'h04);
		end
	end
endmodule

// ==== test/ppm_monitor_checker.sv ====
// Concurrent checks on the monitor ports
`timescale 1ns/1ps
module ppm_monitor_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic cong_irq,
	input wire logic cong_port_write,
	input wire logic cong_irq_en,
	input wire logic cong_pw_en,
	input wire logic [7:0] tx_depth,
	input wire logic [7:0] rx_depth,
	input wire logic [7:0] tx_watermark,
	input wire logic [7:0] rx_watermark,
	input wire logic reorder_irq,
	input wire logic pkt_stalled,
	input wire logic pkt_passed,
	input wire ppm_pkg::ppm_arb_t arb_policy,
	input wire logic [3:0] arb_pending,
	input wire logic [1:0] arb_oldest_prio,
	input wire logic [1:0] arb_grant_prio,
	input wire logic sched_retry,
	input wire logic sched_sent,
	input wire logic sched_send_highest
);
	////////////////
	// Single domain, so clock and reset are given once
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	wire above = tx_depth > tx_watermark || rx_depth > rx_watermark;
	chk_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
	chk_cong_irq:
		assert property (cong_irq |-> $past(cong_irq_en && above)) else $error("bad irq");
	chk_cong_pw:
		assert property (cong_port_write |-> $past(cong_pw_en && above)) else $error("bad pw");
	chk_reorder_irq:
		assert property (reorder_irq |-> $past(pkt_stalled && pkt_passed)) else $error("bad ri");
	chk_arb_oldest:
		assert property (arb_policy == ppm_pkg::PPM_ARB_OLDEST
			|=> arb_grant_prio == $past(arb_oldest_prio)) else $error("bad oldest");
	chk_arb_strict:
		assert property (arb_policy inside {ppm_pkg::PPM_ARB_STRICT1, ppm_pkg::PPM_ARB_STRICT2}
			&& arb_pending[3] |=> arb_grant_prio == 2'h3) else $error("bad strict");
	chk_arb_strict1:
		assert property (arb_policy == ppm_pkg::PPM_ARB_STRICT1 && !arb_pending[3]
			|=> arb_grant_prio == $past(arb_oldest_prio)) else $error("bad strict1");
	chk_arb_strict2:
		assert property (arb_policy == ppm_pkg::PPM_ARB_STRICT2 && !arb_pending[3]
			&& arb_pending[2] |=> arb_grant_prio == 2'h2) else $error("bad strict2");
	chk_sched_retry:
		assert property (sched_retry && !sched_sent |=> sched_send_highest) else $error("no hi");
	chk_sched_resume:
		assert property (sched_sent && !sched_retry |=> !sched_send_highest) else $error("hi");
	cover property (cong_irq);
	cover property (reorder_irq);
	cover property (sched_send_highest);
endmodule
bind ppm_monitor ppm_monitor_checker ppm_monitor_checker_i (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.reg_rd(reg_rd),
	.reg_rvalid(reg_rvalid),
	.cong_irq(cong_irq),
	.cong_port_write(cong_port_write),
	.cong_irq_en(cong_irq_en),
	.cong_pw_en(cong_pw_en),
	.tx_depth(tx_depth),
	.rx_depth(rx_depth),
	.tx_watermark(tx_watermark),
	.rx_watermark(rx_watermark),
	.reorder_irq(reorder_irq),
	.pkt_stalled(pkt_stalled),
	.pkt_passed(pkt_passed),
	.arb_policy(arb_policy),
	.arb_pending(arb_pending),
	.arb_oldest_prio(arb_oldest_prio),
	.arb_grant_prio(arb_grant_prio),
	.sched_retry(sched_retry),
	.sched_sent(sched_sent),
	.sched_send_highest(sched_send_highest)
);

// ==== test/ppm_monitor_tb_top.sv ====
// Self-checking bench for the port performance monitor
`timescale 1ns/1ps
module ppm_monitor_tb_top;
	logic ref_clk = 0, sys_rst = 1, pkt_stalled = 0, pkt_passed = 0, push = 0, pop = 0;
	logic reg_rd = 0, reg_wr = 0, sched_retry = 0, sched_sent = 0, cong_irq_en = 1, cong_pw_en = 1;
	logic reg_rvalid, cong_irq, cong_port_write, reorder_irq, sched_send_highest, a, b, pa, pb;
	ppm_pkg::ppm_pkt_t tx_pkt = '0, rx_pkt = '0;
	ppm_pkg::ppm_stat_cfg_t stat0_cfg = '0, stat1_cfg = '0;
	ppm_pkg::ppm_arb_t arb_policy = ppm_pkg::PPM_ARB_OLDEST;
	logic [7:0] tx_depth, rx_depth, tx_watermark = 8'hff, rx_watermark = 8'hff;
	logic [15:0] period_prescale = 16'h0001;
	logic [31:0] cong_limit = 32'h00000001, reorder_thresh = 32'h00000005, reg_wdata = '0;
	logic [31:0] reg_rdata, exp_q[$];
	logic [2:0] reg_sel = '0;
	logic [3:0] arb_pending = '0;
	logic [1:0] arb_oldest_prio = '0, arb_grant_prio;
	int n_fail = 0, samples_checked = 0, seed = 84, e0, e1, er = 0;
	int ta = 0, tr = 0, ra = 0, rr = 0, n_ci = 0, n_pw = 0, n_ri = 0, pc = 1;
	logic tk;
	ppm_monitor ppm_monitor_i (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.tx_pkt(tx_pkt),
		.rx_pkt(rx_pkt),
		.tx_depth(tx_depth),
		.rx_depth(rx_depth),
		.pkt_stalled(pkt_stalled),
		.pkt_passed(pkt_passed),
		.stat0_cfg(stat0_cfg),
		.stat1_cfg(stat1_cfg),
		.tx_watermark(tx_watermark),
		.rx_watermark(rx_watermark),
		.period_prescale(period_prescale),
		.cong_limit(cong_limit),
		.cong_irq_en(cong_irq_en),
		.cong_pw_en(cong_pw_en),
		.reorder_thresh(reorder_thresh),
		.reg_rd(reg_rd),
		.reg_wr(reg_wr),
		.reg_sel(reg_sel),
		.reg_wdata(reg_wdata),
		.arb_policy(arb_policy),
		.arb_pending(arb_pending),
		.arb_oldest_prio(arb_oldest_prio),
		.sched_retry(sched_retry),
		.sched_sent(sched_sent),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.cong_irq(cong_irq),
		.cong_port_write(cong_port_write),
		.reorder_irq(reorder_irq),
		.arb_grant_prio(arb_grant_prio),
		.sched_send_highest(sched_send_highest)
	);
	ppm_queue_model ppm_queue_model_i (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.push(push),
		.pop(pop),
		.tx_depth(tx_depth),
		.rx_depth(rx_depth)
	);
	////////////////
	// Clock, and shared bus and compare tasks
	initial forever #12.5 ref_clk = ~ref_clk;
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] e);
		samples_checked++;
		if (got !== e) begin
			n_fail++;
			$display("MISMATCH %0t %h %h", $time, got, e);
		end
	endtask
	task rd(input logic [2:0] s, input logic [31:0] e);
		reg_sel = s;
		reg_rd = 1;
		exp_q.push_back(e);
		cyc(1);
		reg_rd = 0;
		// One idle edge, so back-to-back reads never lower and raise in one step
		cyc(1);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Reference rises and prescaled ticks above the watermarks, as the design sees them
	always @(posedge ref_clk) begin
		a = tx_depth > tx_watermark;
		b = rx_depth > rx_watermark;
		tk = pc >= period_prescale;
		if (sys_rst === 1'b0) begin
			ta += a & tk;
			tr += a & !pa;
			ra += b & tk;
			rr += b & !pb;
			pc = tk ? 1 : pc + 1;
		end else begin
			pc = 1;
		end
		pa = a;
		pb = b;
	end
	// Answers are matched with the oldest note; alarm pulses are tallied
	always @(negedge ref_clk) begin
		if (reg_rvalid === 1'b1 && exp_q.size() == 0) begin
			n_fail++;
			$display("MISMATCH %0t %h %h", $time, reg_rdata, 32'h00000000);
		end
		if (reg_rvalid === 1'b1 && exp_q.size() != 0) chk(reg_rdata, exp_q.pop_front());
		n_ci += (cong_irq === 1'b1);
		n_pw += (cong_port_write === 1'b1);
		n_ri += (reorder_irq === 1'b1);
	end
	// Main sequence
	initial begin
		cyc(5);
		sys_rst = 0;
		for (int k = 0; k < 8; k++) rd(k[2:0], 0);
		for (int p = 0; p < 4; p++) begin
			stat0_cfg = '{ppm_pkg::PPM_MODE_PRIO, ppm_pkg::PPM_DIR_TX, p[1:0]};
			stat1_cfg.mode = p[0] ? ppm_pkg::PPM_MODE_ALL : ppm_pkg::PPM_MODE_WORDS;
			stat1_cfg.dir = ppm_pkg::PPM_DIR_RX;
			e0 = 0;
			e1 = 0;
			repeat (40) begin
				tx_pkt = 12'($random(seed));
				rx_pkt = 12'($random(seed));
				{arb_pending, arb_oldest_prio} = 6'($random(seed));
				arb_policy = ppm_pkg::ppm_arb_t'(2'($random(seed)));
				{pkt_stalled, pkt_passed, sched_retry, sched_sent} = 4'($random(seed));
				er += pkt_stalled & pkt_passed;
				e0 += tx_pkt.valid && !tx_pkt.retried && tx_pkt.prio == p;
				e1 += rx_pkt.valid && !rx_pkt.retried ? (p[0] ? 1 : rx_pkt.words) : 0;
				cyc(1);
			end
			{tx_pkt, rx_pkt, pkt_stalled, pkt_passed} = '0;
			rd(0, e0);
			rd(1, e1);
			rd(0, 0);
		end
		reg_sel = 1;
		reg_wdata = 32'hfffffffe;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
		rx_pkt = 12'h800;
		cyc(3);
		rx_pkt = '0;
		rd(1, 32'hffffffff);
		tx_watermark = 8'h02;
		rx_watermark = 8'h01;
		period_prescale = 16'h0003;
		repeat (2) begin
			push = 1;
			cyc(7);
			{push, pop} = 2'b01;
			cyc(7);
			pop = 0;
		end
		rd(2, tr);
		rd(3, ta);
		rd(4, rr);
		rd(5, ra);
		rd(6, er);
		for (int k = 0; k < 10 && exp_q.size() != 0; k++) cyc(1);
		if (exp_q.size() != 0) begin
			n_fail++;
			$display("MISMATCH %0t %h %h", $time, exp_q.size(), 32'h00000000);
		end
		chk(n_ci, 2);
		chk(n_pw, 2);
		chk(n_ri, er >= 5);
		stop_test;
	end
endmodule
